// ==== common/cse_pkg.sv ====
// Purpose: shared constants, types and functions for the control store
//          ecc and bus routing block
// Assumes: word bit 0 is data bit 0; check bits sit above the data bits
// Notes:   column codes use bit 0 for row A through bit 7 for row H
package cse_pkg;
    // ------------------------------------------------------------
    // word format
    // ------------------------------------------------------------
    localparam int DATA_W  = 34;
    localparam int CHK_W   = 8;
    localparam int WORD_W  = 42;
    localparam int ADDR_W  = 13;
    localparam int CHK_LSB = 34;
    localparam logic [3:0] CORR_WEIGHT = 4'h3;
    // one weight-3 column per data bit, bit 33 first; editable table
    localparam logic [33:0][7:0] ECC_COLS = {
        8'h64, 8'h62, 8'h61, 8'h58, 8'h54, 8'h52, 8'h51, 8'h4C,
        8'h4A, 8'h49, 8'h0D, 8'h46, 8'h45, 8'h43, 8'h38, 8'h34,
        8'h32, 8'h31, 8'h2C, 8'h2A, 8'h29, 8'h26, 8'h25, 8'h23,
        8'h1C, 8'h1A, 8'h19, 8'h16, 8'h15, 8'h13, 8'h0E, 8'hC1,
        8'h0B, 8'h07};
    // ------------------------------------------------------------
    // store address fields
    // ------------------------------------------------------------
    localparam int ADDR_WORD_MSB = 7;
    localparam int ADDR_HALF     = 8;
    localparam int ADDR_BRD_LSB  = 9;
    localparam int ADDR_BRD_MSB  = 12;
    localparam int ADDR_EXP      = 12;
    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_SYND    = 8'h08;
    localparam logic [7:0] REG_WORD_LO = 8'h0C;
    localparam logic [7:0] REG_WORD_HI = 8'h10;
    localparam logic [7:0] REG_COUNT   = 8'h14;
    localparam int CTRL_IPL     = 0;
    localparam int CTRL_SERVICE = 1;
    localparam int CTRL_HALT_SW = 2;
    localparam int CTRL_EXP_FIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int ST_DISK    = 0;
    localparam int ST_FATAL   = 1;
    localparam int ST_RUNTIME = 2;
    localparam int ST_CORR    = 3;
    localparam int ST_UNCORR  = 4;
    localparam int ST_HALT    = 5;
    localparam logic [5:0] STATUS_RESET = 6'h00;
    // ------------------------------------------------------------
    // microinstruction formats and branch sources
    // ------------------------------------------------------------
    localparam logic [1:0] FMT0 = 2'h0;
    localparam logic [1:0] FMT2 = 2'h2;
    localparam logic [1:0] FMT3 = 2'h3;
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_G4 = 4'h1;
    localparam logic [3:0] SRC_R1 = 4'h2;
    localparam logic [3:0] SRC_R2 = 4'h3;
    localparam logic [3:0] SRC_R3 = 4'h4;
    localparam logic [3:0] SRC_EV = 4'h5;
    localparam logic [3:0] SRC_R0 = 4'h6;
    localparam logic [3:0] SRC_G7 = 4'h7;
    localparam logic [3:0] SRC_D  = 4'h8;
    localparam logic [3:0] SRC_CH = 4'h9;
    // branch code to source, code 15 first; editable table
    localparam logic [15:0][3:0] BR_MAP = {
        SRC_NONE, SRC_NONE, SRC_NONE, SRC_NONE, SRC_NONE, SRC_NONE,
        SRC_NONE, SRC_CH, SRC_D, SRC_G7, SRC_R0, SRC_EV,
        SRC_R3, SRC_R2, SRC_R1, SRC_G4};
    typedef struct packed {
        logic [1:0]  format;
        logic [3:0]  first_source_select;
        logic [3:0]  second_source_select;
        logic [3:0]  dest_select;
        logic [7:0]  constant_field_bits;
        logic [3:0]  xfer_dest_field;
        logic [3:0]  transfer_code_field;
        logic [31:0] immediate;
    } cse_micro_t;
    typedef struct packed {
        logic [7:0] gp_byte_four;
        logic [7:0] gp_byte_seven;
        logic [7:0] file_byte_zero;
        logic [7:0] file_byte_one;
        logic [7:0] file_byte_two;
        logic [7:0] file_byte_three;
        logic [7:0] event_latch;
        logic [7:0] result_bus;
        logic [7:0] channel_tag_source;
    } cse_br_src_t;
    typedef logic [15:0][7:0] cse_regs_t;
    // check bits of a data word
    function automatic logic [7:0] gen_check(input logic [33:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < DATA_W; i++) begin
            if (d[i]) begin
                c = c ^ ECC_COLS[i];
            end
        end
        return c;
    endfunction
    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction
endpackage

// ==== verilog/cse_top.sv ====
// Purpose: control store ecc check and correct, store select, and
//          routing of the five internal buses
// Assumes: classic wishbone slave on ref_clk; translation and branch
//          condition logic live elsewhere
// Notes:
`timescale 1ns/1ns
module cse_top (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [12:0]         store_addr,
    input  wire logic                store_word_valid,
    input  wire logic [41:0]         base_word,
    input  wire logic [41:0]         exp_word,
    input  wire logic                disk_word_valid,
    input  wire logic [41:0]         disk_word,
    input  wire cse_pkg::cse_micro_t micro,
    input  wire cse_pkg::cse_regs_t  regs_in,
    input  wire logic [7:0]          alu_result,
    input  wire logic [35:0]         t_src_word,
    input  wire cse_pkg::cse_br_src_t br_src,
    input  wire logic [7:0]          page_select_reg,
    output logic [41:0]              corrected_word,
    output logic [7:0]               syndrome,
    output logic                     corrected_pulse,
    output logic                     halt_exec,
    output logic                     disk_read_error,
    output logic                     fatal_load_error,
    output logic                     runtime_check_error,
    output logic [7:0]               exp_word_sel,
    output logic                     exp_half_sel,
    output logic [3:0]               exp_board_sel,
    output logic [3:0]               first_source_select,
    output logic [7:0]               alu_a_bus,
    output logic [7:0]               alu_b_bus,
    output logic [3:0]               d_dest_select,
    output logic [7:0]               d_bus,
    output logic [35:0]              t_bus,
    output logic [3:0]               wide_dest_select,
    output logic [7:0]               br_bus
);
    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic [3:0]  ctrl;
    logic [5:0]  status;
    logic [15:0] corr_count;
    logic        wb_hit;
    logic        wb_wr;
    logic        wb_w1c;
    logic        halt_clr;
    logic [5:0]  status_set;

    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr  = wb_hit & wb_we_i & wb_sel_i[0];
    assign wb_w1c = wb_wr & (wb_adr_i == cse_pkg::REG_STATUS);
    assign halt_clr = wb_w1c & wb_dat_i[cse_pkg::ST_HALT];

    // software settings: load, service mode, halt switch, fitted
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= cse_pkg::CTRL_RESET;
        end else if (ce && wb_wr && wb_adr_i == cse_pkg::REG_CTRL) begin
            ctrl <= wb_dat_i[3:0];
        end
    end

    // ------------------------------------------------------------
    // read path: select, correct, latch
    // ------------------------------------------------------------
    logic [41:0] sel_word;
    logic [7:0]  next_synd;
    logic [3:0]  synd_ones;
    logic [41:0] next_corr;
    logic        hit_bit;
    logic        is_single;
    logic        is_multi;
    logic        halt_cause;

    // the bypass of the jumpers is modelled by the fitted bit
    always_comb begin
        sel_word = base_word;
        if (ctrl[cse_pkg::CTRL_EXP_FIT] &&
            store_addr[cse_pkg::ADDR_EXP]) begin
            sel_word = exp_word;
        end
    end

    // correction is combinational on the selected word so the value
    // captured at the latching edge is already corrected; trades a
    // long path for no extra cycle of latency
    always_comb begin
        next_synd = cse_pkg::gen_check(sel_word[33:0]) ^
                    sel_word[41:34];
        synd_ones = cse_pkg::ones8(next_synd);
        next_corr = sel_word;
        hit_bit   = 1'b0;
        if (synd_ones == cse_pkg::CORR_WEIGHT) begin
            for (int i = 0; i < cse_pkg::DATA_W; i++) begin
                if (cse_pkg::ECC_COLS[i] == next_synd) begin
                    next_corr[i] = ~sel_word[i];
                    hit_bit = 1'b1;
                end
            end
        end
        // a weight-3 code matching no column has no bit to flip
        is_single = hit_bit;
        is_multi  = (next_synd != 8'h00) & ~hit_bit;
        halt_cause = is_multi |
                     (is_single & ctrl[cse_pkg::CTRL_SERVICE] &
                      ctrl[cse_pkg::CTRL_HALT_SW]);
    end

    // display copies of the corrected word and its syndrome
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            corrected_word  <= 42'h000_0000_0000;
            syndrome        <= 8'h00;
            corrected_pulse <= 1'b0;
        end else if (ce) begin
            corrected_pulse <= store_word_valid & is_single;
            if (store_word_valid) begin
                corrected_word <= next_corr;
                syndrome       <= next_synd;
            end
        end
    end

    // corrected-error count, saturating so it never wraps to zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            corr_count <= 16'h0000;
        end else if (ce) begin
            if (wb_wr && wb_adr_i == cse_pkg::REG_COUNT) begin
                corr_count <= 16'h0000;
            end else if (store_word_valid && is_single &&
                         corr_count != 16'hFFFF) begin
                corr_count <= corr_count + 16'h0001;
            end
        end
    end

    // expansion board address split
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            exp_word_sel  <= 8'h00;
            exp_half_sel  <= 1'b0;
            exp_board_sel <= 4'h0;
        end else if (ce) begin
            exp_word_sel  <= store_addr[cse_pkg::ADDR_WORD_MSB:0];
            exp_half_sel  <= store_addr[cse_pkg::ADDR_HALF];
            exp_board_sel <= store_addr[cse_pkg::ADDR_BRD_MSB:
                                        cse_pkg::ADDR_BRD_LSB];
        end
    end

    // ------------------------------------------------------------
    // disk load check and sticky status
    // ------------------------------------------------------------
    logic disk_miss;

    assign disk_miss = disk_word_valid &
        (cse_pkg::gen_check(disk_word[33:0]) != disk_word[41:34]);

    always_comb begin
        status_set = 6'h00;
        status_set[cse_pkg::ST_DISK] = disk_miss;
        status_set[cse_pkg::ST_FATAL] =
            disk_miss & ctrl[cse_pkg::CTRL_IPL];
        status_set[cse_pkg::ST_RUNTIME] =
            disk_miss & ~ctrl[cse_pkg::CTRL_IPL];
        status_set[cse_pkg::ST_CORR]   = store_word_valid & is_single;
        status_set[cse_pkg::ST_UNCORR] = store_word_valid & is_multi;
        status_set[cse_pkg::ST_HALT]   = store_word_valid & halt_cause;
    end

    // write one to clear; a set in the same cycle wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= cse_pkg::STATUS_RESET;
        end else if (ce) begin
            status <= (status & ~(wb_w1c ? wb_dat_i[5:0] : 6'h00)) |
                      status_set;
        end
    end

    // disk, fatal and runtime outputs mirror their sticky flags a cycle behind; halt_exec sets and clears with its flag
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_exec           <= 1'b0;
            disk_read_error     <= 1'b0;
            fatal_load_error    <= 1'b0;
            runtime_check_error <= 1'b0;
        end else if (ce) begin
            halt_exec <= status_set[cse_pkg::ST_HALT] |
                         (halt_exec & ~halt_clr);
            disk_read_error     <= status[cse_pkg::ST_DISK];
            fatal_load_error    <= status[cse_pkg::ST_FATAL];
            runtime_check_error <= status[cse_pkg::ST_RUNTIME];
        end
    end

    // ------------------------------------------------------------
    // bus routing
    // ------------------------------------------------------------
    logic [7:0]  next_a;
    logic [7:0]  next_b;
    logic [3:0]  next_a_sel;
    logic [35:0] next_t;
    logic [3:0]  next_t_dest;
    logic [7:0]  next_br;
    logic [3:0]  br_id;

    // four byte parity bits, odd parity, above the 32 data bits
    function automatic logic [35:0] with_parity(input logic [31:0] v);
        logic [3:0] p;
        for (int k = 0; k < 4; k++) begin
            p[k] = ~(^v[k*8 +: 8]);
        end
        return {p, v};
    endfunction

    always_comb begin
        next_a_sel = micro.first_source_select;
        if (micro.format == cse_pkg::FMT2) begin
            next_a_sel = 4'h0;
        end
        next_a = regs_in[next_a_sel];
        if (micro.format == cse_pkg::FMT2) begin
            next_a = 8'h00;
        end
        next_b = micro.constant_field_bits;
        if (micro.format == cse_pkg::FMT3) begin
            next_b = regs_in[micro.second_source_select];
        end
        next_t      = t_src_word;
        next_t_dest = 4'h0;
        if (micro.format == cse_pkg::FMT0) begin
            next_t      = with_parity(micro.immediate);
            next_t_dest = micro.xfer_dest_field;
        end else if (micro.format == cse_pkg::FMT2) begin
            next_t_dest = micro.transfer_code_field;
        end
    end

    // branch source selection through the editable map
    always_comb begin
        br_id = cse_pkg::BR_MAP[page_select_reg[3:0]];
        unique case (br_id)
            cse_pkg::SRC_G4: next_br = br_src.gp_byte_four;
            cse_pkg::SRC_R1: next_br = br_src.file_byte_one;
            cse_pkg::SRC_R2: next_br = br_src.file_byte_two;
            cse_pkg::SRC_R3: next_br = br_src.file_byte_three;
            cse_pkg::SRC_EV: next_br = br_src.event_latch;
            cse_pkg::SRC_R0: next_br = br_src.file_byte_zero;
            cse_pkg::SRC_G7: next_br = br_src.gp_byte_seven;
            cse_pkg::SRC_D:  next_br = br_src.result_bus;
            cse_pkg::SRC_CH: next_br = br_src.channel_tag_source;
            default:         next_br = 8'h00;
        endcase
    end

    // registered bus outputs, one cycle behind the fields
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_source_select <= 4'h0;
            alu_a_bus        <= 8'h00;
            alu_b_bus        <= 8'h00;
            d_dest_select    <= 4'h0;
            d_bus            <= 8'h00;
            t_bus            <= 36'h0_0000_0000;
            wide_dest_select <= 4'h0;
            br_bus           <= 8'h00;
        end else if (ce) begin
            first_source_select <= next_a_sel;
            alu_a_bus        <= next_a;
            alu_b_bus        <= next_b;
            d_dest_select    <= micro.dest_select;
            d_bus            <= alu_result;
            t_bus            <= next_t;
            wide_dest_select <= next_t_dest;
            br_bus           <= next_br;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    // unmapped offsets read as zero and ignore writes
    always_comb begin
        unique case (wb_adr_i)
            cse_pkg::REG_CTRL:    rd_mux = {28'h0, ctrl};
            cse_pkg::REG_STATUS:  rd_mux = {26'h0, status};
            cse_pkg::REG_SYND:    rd_mux = {24'h0, syndrome};
            cse_pkg::REG_WORD_LO: rd_mux = corrected_word[31:0];
            cse_pkg::REG_WORD_HI: rd_mux = {22'h0, corrected_word[41:32]};
            cse_pkg::REG_COUNT:   rd_mux = {16'h0, corr_count};
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    // answer one edge after the strobe; ack drops the next cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack_o <= wb_hit;
            if (wb_hit) begin
                wb_dat_o <= rd_mux;
            end
        end
    end
endmodule

// ==== verification/cse_store_model.sv ====
// Purpose: behavioural control store boards, base and expansion
// Assumes: read data follows the address with no wait state
// Notes:   flip injects dropped or picked-up bits into both words
`timescale 1ns/1ns
module cse_store_model (
    input  wire logic [12:0] addr,
    input  wire logic [41:0] flip,
    output logic      [41:0] base_word,
    output logic      [41:0] exp_word
);
    logic [33:0] db;
    logic [7:0]  cb;
    logic [7:0]  cx;
    // ----------
    // store words
    // ----------
    // data follows the address; expansion holds its inverse so the
    // bench can tell which store answered
    always_comb begin
        db = {21'h0, addr};
        cb = 8'h00;
        cx = 8'h00;
        for (int i = 0; i < 34; i++) begin
            cb = cb ^ (db[i] ? cse_pkg::ECC_COLS[i] : 8'h00);
            cx = cx ^ (db[i] ? 8'h00 : cse_pkg::ECC_COLS[i]);
        end
        base_word = {cb, db} ^ flip;
        exp_word  = {cx, ~db} ^ flip;
    end
endmodule

// ==== verification/cse_top_properties.sv ====
// Purpose: port-level checks on the ecc and bus routing block
// Assumes: one ref_clk domain, reset rst_n
// Notes:   run masks the two edges after reset release
`timescale 1ns/1ns
module cse_top_properties (
    input wire logic                 ref_clk,
    input wire logic                 rst_n,
    input wire logic                 ce,
    input wire logic [12:0]          store_addr,
    input wire logic                 store_word_valid,
    input wire cse_pkg::cse_micro_t  micro,
    input wire cse_pkg::cse_regs_t   regs_in,
    input wire logic [7:0]           alu_result,
    input wire cse_pkg::cse_br_src_t br_src,
    input wire logic [7:0]           page_select_reg,
    input wire logic [7:0]           syndrome,
    input wire logic                 halt_exec,
    input wire logic [7:0]           exp_word_sel,
    input wire logic                 exp_half_sel,
    input wire logic [3:0]           exp_board_sel,
    input wire logic [7:0]           alu_a_bus,
    input wire logic [7:0]           alu_b_bus,
    input wire logic [3:0]           d_dest_select,
    input wire logic [7:0]           d_bus,
    input wire logic [35:0]          t_bus,
    input wire logic [3:0]           wide_dest_select,
    input wire logic [7:0]           br_bus
);
    logic [1:0] run_q;
    wire        run = run_q[1] && ce;
    // ----------
    // checks
    // ----------
    // outputs hold zero just after reset, so relations start later
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 2'h0;
        end else begin
            run_q <= {run_q[0], 1'b1};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_uncorr_halt: assert property (
        (run && store_word_valid) ##1 (syndrome != 8'h00 &&
        $countones(syndrome) != 3) |-> ##[0:1] halt_exec)
        else $error("no halt on uncorrectable syndrome");
    chk_fmt2_zero: assert property (
        run && micro.format == cse_pkg::FMT2 |=> alu_a_bus == 8'h00 &&
        wide_dest_select == $past(micro.transfer_code_field))
        else $error("format 2 first operand not zero");
    chk_b_register: assert property (
        run && micro.format == cse_pkg::FMT3 |=>
        alu_b_bus == $past(regs_in[micro.second_source_select]))
        else $error("format 3 second operand wrong");
    chk_b_constant: assert property (
        run && micro.format != cse_pkg::FMT3 |=>
        alu_b_bus == $past(micro.constant_field_bits))
        else $error("second operand constant wrong");
    chk_d_route: assert property (
        run |=> d_bus == $past(alu_result) &&
        d_dest_select == $past(micro.dest_select))
        else $error("result bus routing wrong");
    chk_t_immediate: assert property (
        run && micro.format == cse_pkg::FMT0 |=>
        t_bus[31:0] == $past(micro.immediate) &&
        wide_dest_select == $past(micro.xfer_dest_field))
        else $error("format 0 wide bus wrong");
    chk_t_parity: assert property (
        run |-> t_bus[32] == ~^t_bus[7:0] && t_bus[35] == ~^t_bus[31:24])
        else $error("wide bus parity wrong");
    chk_addr_split: assert property (
        run |=> {exp_board_sel, exp_half_sel, exp_word_sel} ==
        $past(store_addr)) else $error("store address split wrong");
    chk_br_code: assert property (
        run && page_select_reg[3:0] == 4'h0 |=>
        br_bus == $past(br_src.gp_byte_four)) else $error("branch bus wrong");
    cover property (halt_exec);
    cover property (micro.format == cse_pkg::FMT2);
    cover property (micro.format == cse_pkg::FMT0);
endmodule
bind cse_top cse_top_properties u_chk (.ref_clk, .rst_n, .ce, .store_addr,
    .store_word_valid, .micro, .regs_in, .alu_result, .br_src,
    .page_select_reg, .syndrome, .halt_exec, .exp_word_sel, .exp_half_sel,
    .exp_board_sel, .alu_a_bus, .alu_b_bus, .d_dest_select, .d_bus, .t_bus,
    .wide_dest_select, .br_bus);

// ==== verification/control_store_ecc_and_bus_routing_tb.sv ====
// Purpose: self-checking bench for the ecc and bus routing block
// Assumes: ce held high; store words come from cse_store_model
// Notes:   every wait is bounded and ends in end_sim
`timescale 1ns/1ns
module control_store_ecc_and_bus_routing_tb;
    logic        ref_clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, halt_exec;
    logic        store_word_valid = 1'b0, disk_word_valid = 1'b0;
    logic        disk_read_error, fatal_load_error, runtime_check_error;
    logic [7:0]  wb_adr_i = 8'h00, page_select_reg = 8'h00, syndrome;
    logic [7:0]  alu_result = 8'h5A, alu_a_bus, alu_b_bus, br_bus;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [12:0] store_addr = 13'h0;
    logic [41:0] flip = 42'h0, disk_word = 42'h0;
    logic [41:0] base_word, exp_word, corrected_word;
    logic [35:0] t_bus;
    logic [7:0]  brx [10] = '{8'h11, 8'h44, 8'h55, 8'h66, 8'h77, 8'h33,
                             8'h22, 8'h88, 8'h99, 8'h00};
    cse_pkg::cse_micro_t  micro = '0;
    cse_pkg::cse_regs_t   regs_in = 128'h0123456789ABCDEF_FEDCBA9876543210;
    cse_pkg::cse_br_src_t br_src = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
                                    8'h66, 8'h77, 8'h88, 8'h99};
    int          err_total = 0;
    int          compares = 0;
    // ----------
    // clock, parts and tasks
    // ----------
    always #20 ref_clk = ~ref_clk;
    cse_store_model u_mem (.addr(store_addr), .flip, .base_word, .exp_word);
    cse_top u_dut (.ref_clk, .rst_n, .ce(1'b1), .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .store_addr, .store_word_valid, .base_word, .exp_word,
        .disk_word_valid, .disk_word, .micro, .regs_in, .alu_result,
        .t_src_word(36'hF_0000_0000), .br_src, .page_select_reg, .corrected_word,
        .syndrome, .corrected_pulse(), .halt_exec, .disk_read_error,
        .fatal_load_error, .runtime_check_error, .exp_word_sel(),
        .exp_half_sel(), .exp_board_sel(), .first_source_select(),
        .alu_a_bus, .alu_b_bus, .d_dest_select(), .d_bus(), .t_bus,
        .wide_dest_select(), .br_bus);
    task end_sim;
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cmp(input logic [41:0] g, input logic [41:0] e, input string m);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w;
        wb_adr_i <= a; wb_dat_i <= d;
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1) begin
            n++;
            if (n > 20) begin err_total++; end_sim; end
            @(posedge ref_clk);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
        @(posedge ref_clk);
    endtask
    task st(input logic [12:0] a, input logic [41:0] f);
        store_addr <= a; flip <= f; store_word_valid <= 1'b1;
        @(posedge ref_clk);
        store_word_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task dk(input logic bad);
        disk_word <= base_word ^ {41'h0, bad}; disk_word_valid <= 1'b1;
        @(posedge ref_clk);
        disk_word_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        wb(0, cse_pkg::REG_STATUS, 0); cmp(rd, 0, "status reset");
        wb(0, cse_pkg::REG_CTRL, 0); cmp(rd, 0, "ctrl reset");
        wb(1, 8'h40, 32'hFF); wb(0, 8'h40, 0); cmp(rd, 0, "unmapped");
        $display("test registers done");
        wb(1, cse_pkg::REG_CTRL, 32'h8);
        st(13'h0055, 0); cmp(syndrome, 0, "clean syndrome");
        cmp(corrected_word[33:0], 34'h55, "base word");
        st(13'h1055, 0);
        cmp(corrected_word[33:0], 34'h3FFFFEFAA, "exp");
        st(13'h0055, 42'h4); cmp(syndrome, 8'hC1, "bit 2");
        cmp(corrected_word[33:0], 34'h55, "fixed");
        cmp(halt_exec, 0, "halt on single");
        st(13'h0055, 42'h800000); cmp(syndrome, 8'h0D, "bit 23");
        wb(0, cse_pkg::REG_SYND, 0); cmp(rd, 32'h0D, "shown");
        wb(0, cse_pkg::REG_STATUS, 0); cmp(rd[3], 1, "corr seen");
        st(13'h0055, 42'h3); cmp(halt_exec, 1, "double");
        wb(1, cse_pkg::REG_STATUS, 32'h3F); cmp(halt_exec, 0, "cleared");
        st(13'h0055, 42'h400000000); cmp(halt_exec, 1, "check bit");
        wb(1, cse_pkg::REG_STATUS, 32'h3F);
        wb(1, cse_pkg::REG_CTRL, 0);
        st(13'h1055, 0); cmp(corrected_word[33:0], 34'h1055, "bypass");
        wb(1, cse_pkg::REG_CTRL, 32'h6);
        st(13'h0055, 42'h4); cmp(halt_exec, 1, "service halt");
        wb(1, cse_pkg::REG_STATUS, 32'h3F);
        $display("test store ecc done");
        wb(1, cse_pkg::REG_CTRL, 32'h1); st(13'h0055, 0);
        dk(1); cmp(disk_read_error, 1, "disk err");
        cmp(fatal_load_error, 1, "fatal");
        cmp(runtime_check_error, 0, "no runtime");
        wb(1, cse_pkg::REG_STATUS, 32'h3F); wb(1, cse_pkg::REG_CTRL, 0);
        dk(1); cmp(runtime_check_error, 1, "runtime");
        cmp(fatal_load_error, 0, "not fatal");
        wb(1, cse_pkg::REG_STATUS, 32'h3F);
        dk(0); cmp(disk_read_error, 0, "clean disk");
        $display("test disk check done");
        micro <= {cse_pkg::FMT2, 24'h359A56, 4'hC, 32'h80FF0103};
        alu_result <= 8'hC3;
        repeat (2) @(posedge ref_clk);
        cmp(alu_a_bus, 0, "fmt2 a");
        cmp(alu_b_bus, 8'hA5, "fmt2 b");
        micro.format <= cse_pkg::FMT3;
        repeat (2) @(posedge ref_clk);
        cmp(alu_a_bus, regs_in[3], "fmt3 a");
        cmp(alu_b_bus, regs_in[5], "fmt3 b");
        micro.format <= cse_pkg::FMT0;
        repeat (2) @(posedge ref_clk);
        cmp(t_bus, 36'h580FF0103, "wide bus");
        for (int i = 0; i < 10; i++) begin
            page_select_reg <= {4'h0, 4'(i)};
            repeat (2) @(posedge ref_clk);
            cmp(br_bus, brx[i], "branch bus");
        end
        $display("test buses done");
        end_sim;
    end
endmodule
